/* File: verilog/power_save_pkg.sv */
// Purpose: Shared constants for the power-save and wakeup sequencer.
// Assumes: One 25 MHz clock, registers reached over AXI4-Lite.
// Notes: Offsets are byte addresses of aligned 32-bit words.
// What this block does
// - Halt flag write of one enters full stop.
// - Full stop freezes clocks and all timers.
// - Watchdog off in stop; monitor drives pin low.
// - Stop exits on wake pin, clock-pin rise with RC option, reset.
// - Wake loads idle timer 256, counts, then clocks.
// - Instruction cycle is oscillator divided by ten.
// - RC option delays only with delay enable set.
// - Halt disabled option: flag ignored, reads zero.
// - Idle flag write stops all but oscillator, idle timer, watchdog.
// - Both modes keep state and other timers.
// - Idle exits on reset, wake pin, bit toggle.
// - Bit toggle sets pending; interrupt when enabled.
// - Idle with interrupt enabled services first.
// - Eight-bit wakeup enable, one bit per pin.
// - Edge select set means falling, clear rising.
// - Wakeup logic also gives one combined port L interrupt.
// - Edge sets sticky pending; stop refused if an enabled pin is pending.
// - Wakeup registers read/write, cleared by reset.
package power_save_pkg;
    // Register byte offsets.
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_PIN_EN   = 8'h04;
    localparam logic [7:0]  ADDR_EDGE_SEL = 8'h08;
    localparam logic [7:0]  ADDR_PEND     = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;
    // Control register fields.
    localparam int unsigned CTRL_DELAY_BIT = 0;
    localparam int unsigned CTRL_TIE_BIT   = 1;
    localparam int unsigned CTRL_CMEN_BIT  = 2;
    localparam int unsigned CTRL_TPND_BIT  = 3;
    localparam int unsigned CTRL_IDLE_BIT  = 6;
    localparam int unsigned CTRL_HALT_BIT  = 7;
    localparam logic        CMEN_RESET     = 1'b1;
    // Status register fields.
    localparam int unsigned STAT_TMR_LSB   = 16;
    // Port L width and timing.
    localparam int unsigned PORT_L_W       = 8;
    localparam int unsigned TMR_W          = 16;
    localparam int unsigned TC_DIV         = 10;
    localparam int unsigned DIV_W          = 4;
    localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(TC_DIV - 1);
    localparam logic [TMR_W-1:0] SETTLE_LOAD = 16'h0100;
    localparam logic [TMR_W-1:0] TMR_ONE   = 16'h0001;
    localparam int unsigned TOGGLE_BIT_DEF = 13;
    // AXI responses.
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    // Operating modes.
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_HALT   = 2'b01,
        ST_IDLE   = 2'b10,
        ST_SETTLE = 2'b11
    } mode_e;
endpackage

/* File: verilog/wakeup_edge_detect.sv */
// Purpose: Per-pin selectable edge detector for port L.
// Assumes: Pins are synchronous to clk_i.
// Notes: Runs on the free clock, not the gated core clock.
`timescale 1ns/100ps
`default_nettype none
module wakeup_edge_detect
    import power_save_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic [PORT_L_W-1:0] pin_i,
    input  wire logic [PORT_L_W-1:0] falling_sel_i,
    output logic      [PORT_L_W-1:0] edge_o
);
    logic [PORT_L_W-1:0] prev_reg;

    // Previous pin levels.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            prev_reg <= '0;
        else
            prev_reg <= pin_i;
    end

    // Each pin picks its own trigger edge.
    genvar g;
    generate
        for (g = 0; g < PORT_L_W; g++)
        begin : g_pin
            assign edge_o[g] = falling_sel_i[g] ? (prev_reg[g] & ~pin_i[g])
                                                : (~prev_reg[g] & pin_i[g]);
        end
    endgenerate
endmodule
`default_nettype wire

/* File: verilog/power_save_wakeup_control.sv */
// Purpose: Full-stop and oscillator-only sleep sequencer with port L wakeup.
// Assumes: clk_i is the oscillator clock; pins are synchronous to it.
// Notes: Outputs follow the mode one cycle late.
`timescale 1ns/100ps
`default_nettype none
module power_save_wakeup_control
    import power_save_pkg::*;
#(
    parameter int unsigned IDLE_TOGGLE_BIT = TOGGLE_BIT_DEF
)
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                halt_enable_option_i,
    input  wire logic                rc_clock_option_i,
    input  wire logic [PORT_L_W-1:0] port_l_i,
    input  wire logic                clock_output_pin_i,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic                     oscillator_enable_o,
    output logic                     core_clock_enable_o,
    output logic                     timer_clock_enable_o,
    output logic                     tc_enable_o,
    output logic                     watchdog_run_o,
    output logic                     watchdog_output_pin_n_o,
    output logic                     idle_timer_irq_o,
    output logic                     port_l_irq_o,
    output logic                     service_first_o,
    output logic                     resume_direct_o
);
    mode_e               state_reg;
    logic [DIV_W-1:0]    div_reg;
    logic [TMR_W-1:0]    tmr_reg;
    logic [TMR_W-1:0]    tmr_inc;
    logic [PORT_L_W-1:0] pin_en_reg;
    logic [PORT_L_W-1:0] edge_sel_reg;
    logic [PORT_L_W-1:0] pend_reg;
    logic [PORT_L_W-1:0] edge_w;
    logic                delay_en_reg;
    logic                tmr_ie_reg;
    logic                cm_en_reg;
    logic                tmr_pend_reg;
    logic                ie_at_entry_reg;
    logic                clkout_prev_reg;
    logic                aw_held_reg;
    logic                w_held_reg;
    logic [7:0]          awaddr_reg;
    logic [31:0]         wdata_reg;
    logic                wstrb0_reg;
    logic                wr_fire;
    logic                wr_ok;
    logic                wr_ctrl;
    logic [31:0]         rd_data;
    logic                rd_ok;
    logic                tc_tick;
    logic                wake_pin;
    logic                clkout_rise;
    logic                halt_exit;
    logic                settle_needed;
    logic                halt_req_wr;
    logic                idle_req_wr;
    logic                halt_ok;
    logic                tmr_toggle;
    logic                idle_exit;
    logic                settle_done;

    // Port L edges, detected on the free-running clock.
    wakeup_edge_detect u_edge (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .pin_i         (port_l_i),
        .falling_sel_i (edge_sel_reg),
        .edge_o        (edge_w)
    );

    // Wake and entry conditions.
    assign wake_pin      = |(pin_en_reg & pend_reg);
    assign clkout_rise   = rc_clock_option_i & clock_output_pin_i & ~clkout_prev_reg;
    assign halt_exit     = (state_reg == ST_HALT) && (wake_pin || clkout_rise);
    assign settle_needed = !rc_clock_option_i || delay_en_reg;
    assign wr_ctrl       = wr_fire && wstrb0_reg && (awaddr_reg == ADDR_CTRL);
    assign halt_req_wr   = wr_ctrl && wdata_reg[CTRL_HALT_BIT];
    assign idle_req_wr   = wr_ctrl && wdata_reg[CTRL_IDLE_BIT];
    assign halt_ok       = halt_req_wr && halt_enable_option_i && !wake_pin;
    assign idle_exit     = (state_reg == ST_IDLE) && (wake_pin || tmr_toggle);
    assign settle_done   = (state_reg == ST_SETTLE) && tc_tick && (tmr_reg == TMR_ONE);

    // Instruction-cycle divider; it clears to zero and stops ticking in full stop.
    assign tc_tick = (state_reg != ST_HALT) && (div_reg == DIV_LAST);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            div_reg <= '0;
        else if (state_reg == ST_HALT)
            div_reg <= '0;
        else if (div_reg == DIV_LAST)
            div_reg <= '0;
        else
            div_reg <= DIV_W'(div_reg + 1'b1);
    end

    // Idle timer: counts up normally, down from the load while settling.
    assign tmr_inc    = TMR_W'(tmr_reg + 1'b1);
    assign tmr_toggle = tc_tick && (state_reg != ST_SETTLE)
                        && (tmr_inc[IDLE_TOGGLE_BIT] != tmr_reg[IDLE_TOGGLE_BIT]);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            tmr_reg <= '0;
        else if (halt_exit && settle_needed)
            tmr_reg <= SETTLE_LOAD;
        else if (tc_tick && state_reg == ST_SETTLE)
            tmr_reg <= TMR_W'(tmr_reg - 1'b1);
        else if (tc_tick)
            tmr_reg <= tmr_inc;
    end

    // Mode sequencer.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg       <= ST_RUN;
            ie_at_entry_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_RUN:
                begin
                    if (halt_ok)
                        state_reg <= ST_HALT;
                    else if (idle_req_wr)
                    begin
                        state_reg       <= ST_IDLE;
                        ie_at_entry_reg <= tmr_ie_reg;
                    end
                end
                ST_HALT:
                begin
                    if (halt_exit && settle_needed)
                        state_reg <= ST_SETTLE;
                    else if (halt_exit)
                        state_reg <= ST_RUN;
                end
                ST_IDLE:
                begin
                    if (idle_exit)
                        state_reg <= ST_RUN;
                end
                ST_SETTLE:
                begin
                    if (settle_done)
                        state_reg <= ST_RUN;
                end
                default:
                    state_reg <= ST_RUN;
            endcase
        end
    end

    // Clock-pin history for rising-edge wake.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            clkout_prev_reg <= 1'b0;
        else
            clkout_prev_reg <= clock_output_pin_i;
    end

    // Control bits; a timer toggle beats a clear in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            delay_en_reg <= 1'b0;
            tmr_ie_reg   <= 1'b0;
            cm_en_reg    <= CMEN_RESET;
            tmr_pend_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                delay_en_reg <= wdata_reg[CTRL_DELAY_BIT];
                tmr_ie_reg   <= wdata_reg[CTRL_TIE_BIT];
                cm_en_reg    <= wdata_reg[CTRL_CMEN_BIT];
            end
            tmr_pend_reg <= (wr_ctrl ? wdata_reg[CTRL_TPND_BIT] : tmr_pend_reg) | tmr_toggle;
        end
    end

    // Wakeup registers; a new edge beats a software clear.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_en_reg   <= '0;
            edge_sel_reg <= '0;
            pend_reg     <= '0;
        end
        else
        begin
            if (wr_fire && wstrb0_reg && awaddr_reg == ADDR_PIN_EN)
                pin_en_reg <= wdata_reg[PORT_L_W-1:0];
            if (wr_fire && wstrb0_reg && awaddr_reg == ADDR_EDGE_SEL)
                edge_sel_reg <= wdata_reg[PORT_L_W-1:0];
            if (wr_fire && wstrb0_reg && awaddr_reg == ADDR_PEND)
                pend_reg <= wdata_reg[PORT_L_W-1:0] | edge_w;
            else
                pend_reg <= pend_reg | edge_w;
        end
    end

    // Registered outputs that follow the mode.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            oscillator_enable_o     <= 1'b1;
            core_clock_enable_o     <= 1'b1;
            timer_clock_enable_o    <= 1'b1;
            tc_enable_o             <= 1'b0;
            watchdog_run_o          <= 1'b1;
            watchdog_output_pin_n_o <= 1'b1;
            idle_timer_irq_o        <= 1'b0;
            port_l_irq_o            <= 1'b0;
            service_first_o         <= 1'b0;
            resume_direct_o         <= 1'b0;
        end
        else
        begin
            oscillator_enable_o     <= (state_reg != ST_HALT);
            core_clock_enable_o     <= (state_reg == ST_RUN);
            timer_clock_enable_o    <= (state_reg == ST_RUN);
            tc_enable_o             <= tc_tick;
            watchdog_run_o          <= (state_reg != ST_HALT);
            watchdog_output_pin_n_o <= !((state_reg == ST_HALT) && cm_en_reg);
            idle_timer_irq_o        <= tmr_pend_reg && tmr_ie_reg;
            port_l_irq_o            <= wake_pin;
            service_first_o         <= idle_exit && ie_at_entry_reg;
            resume_direct_o         <= (idle_exit && !ie_at_entry_reg) || settle_done
                                       || (halt_exit && !settle_needed);
        end
    end

    // Write channel: address and data taken in either order.
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_ok   = (awaddr_reg == ADDR_CTRL) || (awaddr_reg == ADDR_PIN_EN)
                     || (awaddr_reg == ADDR_EDGE_SEL) || (awaddr_reg == ADDR_PEND)
                     || (awaddr_reg == ADDR_STATUS);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (!aw_held_reg && !s_axi_bvalid && !s_axi_awready)
                s_axi_awready <= 1'b1;
            if (!w_held_reg && !s_axi_bvalid && !s_axi_wready)
                s_axi_wready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg   <= 1'b1;
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg   <= 1'b1;
                wdata_reg    <= s_axi_wdata;
                wstrb0_reg   <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode; the halt flag reads zero when halt is disabled.
    always_comb
    begin
        rd_data = '0;
        rd_ok   = 1'b1;
        if (s_axi_araddr == ADDR_CTRL)
        begin
            rd_data[CTRL_DELAY_BIT] = delay_en_reg;
            rd_data[CTRL_TIE_BIT]   = tmr_ie_reg;
            rd_data[CTRL_CMEN_BIT]  = cm_en_reg;
            rd_data[CTRL_TPND_BIT]  = tmr_pend_reg;
            rd_data[CTRL_IDLE_BIT]  = (state_reg == ST_IDLE);
            rd_data[CTRL_HALT_BIT]  = (state_reg == ST_HALT) && halt_enable_option_i;
        end
        else if (s_axi_araddr == ADDR_PIN_EN)
            rd_data[PORT_L_W-1:0] = pin_en_reg;
        else if (s_axi_araddr == ADDR_EDGE_SEL)
            rd_data[PORT_L_W-1:0] = edge_sel_reg;
        else if (s_axi_araddr == ADDR_PEND)
            rd_data[PORT_L_W-1:0] = pend_reg;
        else if (s_axi_araddr == ADDR_STATUS)
        begin
            rd_data[1:0]                        = state_reg;
            rd_data[STAT_TMR_LSB +: TMR_W]      = tmr_reg;
        end
        else
            rd_ok = 1'b0;
    end

    // Read channel: one cycle from address to data.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Checks on the sequencer.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_halt_enter;
        (state_reg == ST_RUN) && halt_ok |=> (state_reg == ST_HALT);
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("Halt write did not stop the core.");

    property p_osc_off;
        (state_reg == ST_HALT) [*2] |-> !oscillator_enable_o && !tc_tick;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("Oscillator ran during full stop.");

    property p_wdog_pin;
        (state_reg == ST_HALT) && cm_en_reg |=> !watchdog_output_pin_n_o && !watchdog_run_o;
    endproperty
    a_wdog_pin: assert property (p_wdog_pin) else $error("Watchdog pin not low in full stop.");

    property p_halt_wake;
        (state_reg == ST_HALT) && wake_pin |=> (state_reg != ST_HALT);
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("Enabled wake pin did not end full stop.");

    property p_settle_load;
        halt_exit && settle_needed |=> (state_reg == ST_SETTLE) && (tmr_reg == SETTLE_LOAD);
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("Settle did not load the timer.");

    property p_tc_div;
        tc_tick |=> !tc_tick [*8];
    endproperty
    a_tc_div: assert property (p_tc_div) else $error("Instruction tick came too soon.");

    property p_no_delay;
        halt_exit && !settle_needed |=> (state_reg == ST_RUN);
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("Undelayed wake did not resume at once.");

    property p_halt_off;
        (state_reg == ST_RUN) && halt_req_wr && !halt_enable_option_i |=> (state_reg != ST_HALT);
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("Halt entered while disabled.");

    property p_core_gated;
        (state_reg != ST_RUN) |=> !core_clock_enable_o && !timer_clock_enable_o;
    endproperty
    a_core_gated: assert property (p_core_gated) else $error("Core clock ran in a sleep mode.");

    property p_idle_exit;
        (state_reg == ST_IDLE) && tmr_toggle |=> (state_reg == ST_RUN) && tmr_pend_reg;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("Timer toggle did not end idle.");

    property p_pend_set;
        (|edge_w) |=> ((pend_reg & $past(edge_w)) == $past(edge_w));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("Selected edge lost from pending.");

    property p_refuse;
        (state_reg == ST_RUN) && halt_req_wr && wake_pin |=> (state_reg != ST_HALT);
    endproperty
    a_refuse: assert property (p_refuse) else $error("Full stop entered with a pending wake.");

    c_halt:   cover property ((state_reg == ST_HALT) ##1 (state_reg == ST_SETTLE));
    c_settle: cover property (settle_done);
    c_idle:   cover property ((state_reg == ST_IDLE) && idle_exit && ie_at_entry_reg);
    c_write:  cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

/* File: tb/port_l_model.sv */
// Purpose: Pin model for port L and the clock pin, as the outside world drives them.
// Assumes: Levels change just after a rising clock edge.
// Notes: Pins are driven inputs, so they hold their level between changes.
`timescale 1ns/100ps
`default_nettype none
module port_l_model
    import power_save_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [PORT_L_W-1:0] level_i,
    input  wire logic                rise_i,
    output logic      [PORT_L_W-1:0] port_l_o,
    output logic                     clock_pin_o
);
    // Pins take the requested levels one edge later.
    always_ff @(posedge clk_i)
    begin
        port_l_o    <= level_i;
        clock_pin_o <= rise_i;
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the power-save sequencer.
// Assumes: Registers reached over AXI4-Lite; idle toggle bit shortened to 3.
// Notes: Outputs are read right after an edge, before that edge's updates land.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import power_save_pkg::*;
    logic clk_i = 1'h0, rst_n_i = 1'h0, halt_enable_option_i = 1'h1, rc_clock_option_i = 1'h0, ck = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pl = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata;
    logic oscillator_enable_o, core_clock_enable_o, timer_clock_enable_o, tc_enable_o, watchdog_run_o;
    logic watchdog_output_pin_n_o, idle_timer_irq_o, port_l_irq_o, service_first_o, resume_direct_o;
    wire [7:0] port_l_i;
    wire clock_output_pin_i;
    int error_cnt = 0, n_tests = 0, i, n;
    power_save_wakeup_control #(.IDLE_TOGGLE_BIT(3)) dut (.*);
    port_l_model pins (.clk_i(clk_i), .level_i(pl), .rise_i(ck), .port_l_o(port_l_i), .clock_pin_o(clock_output_pin_i));
    // Clock of 40 ns period.
    always #20 clk_i = ~clk_i;
    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Write holds each channel until its own handshake edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
        for (k = 0; k < 99; k++)
        begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp; return;
            end
        end
        error_cnt++; end_sim();
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        for (k = 0; k < 99; k++)
        begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata; r = s_axi_rresp; return;
            end
        end
        error_cnt++; end_sim();
    endtask
    // Polls the mode field until it shows m.
    task automatic wmode(input logic [1:0] m);
        int k;
        for (k = 0; k < 1000; k++)
        begin
            rd(ADDR_STATUS);
            if (d[1:0] === m) return;
        end
        error_cnt++; end_sim();
    endtask
    task automatic t_regs();
        rd(ADDR_PIN_EN); chk(d, 0); rd(ADDR_EDGE_SEL); chk(d, 0); rd(ADDR_PEND); chk(d, 0);
        rd(ADDR_CTRL); chk(d, 32'h04);
        rd(8'h14); chk(r, RESP_SLVERR); wr(8'h14, 1); chk(r, RESP_SLVERR);
        wr(ADDR_PIN_EN, 32'hA5); rd(ADDR_PIN_EN); chk(d, 32'hA5); wr(ADDR_PIN_EN, 0);
        for (i = 0; i < 20 && tc_enable_o !== 1'h1; i++) @(posedge clk_i);
        for (n = 1; n < 20; n++) begin @(posedge clk_i); if (tc_enable_o === 1'h1) break; end
        chk(n, 10);
        $display("register test done");
    endtask
    task automatic t_edge();
        wr(ADDR_EDGE_SEL, 32'h02); pl <= 8'h03; repeat (4) @(posedge clk_i);
        rd(ADDR_PEND); chk(d, 32'h01); pl <= 8'h00; repeat (4) @(posedge clk_i);
        rd(ADDR_PEND); chk(d, 32'h03); chk(port_l_irq_o, 0);
        wr(ADDR_PIN_EN, 32'h02); repeat (3) @(posedge clk_i); chk(port_l_irq_o, 1);
        wr(ADDR_CTRL, 32'h84); rd(ADDR_STATUS); chk(d[1:0], ST_RUN);
        pl <= 8'h02; wr(ADDR_PEND, 0);
        $display("edge test done");
    endtask
    task automatic t_halt();
        wr(ADDR_CTRL, 32'h84); repeat (2) @(posedge clk_i); wmode(ST_HALT);
        chk({oscillator_enable_o, core_clock_enable_o, timer_clock_enable_o}, 0);
        chk({watchdog_run_o, watchdog_output_pin_n_o}, 0);
        pl <= 8'h00; wmode(ST_SETTLE); chk({oscillator_enable_o, core_clock_enable_o}, 2);
        wmode(ST_RUN); chk(core_clock_enable_o, 1); wr(ADDR_PEND, 0);
        rc_clock_option_i <= 1'h1; wr(ADDR_CTRL, 32'h80); wmode(ST_HALT);
        chk(watchdog_output_pin_n_o, 1); ck <= 1'h1;
        for (i = 0; i < 20 && resume_direct_o !== 1'h1; i++) @(posedge clk_i);
        chk(resume_direct_o, 1);
        rd(ADDR_STATUS); chk(d[1:0], ST_RUN); ck <= 1'h0;
        wr(ADDR_CTRL, 32'h81); wmode(ST_HALT); ck <= 1'h1; wmode(ST_SETTLE); wmode(ST_RUN);
        ck <= 1'h0; rc_clock_option_i <= 1'h0; halt_enable_option_i <= 1'h0;
        wr(ADDR_CTRL, 32'h80); rd(ADDR_CTRL); chk(d[7], 0); rd(ADDR_STATUS); chk(d[1:0], ST_RUN);
        halt_enable_option_i <= 1'h1;
        $display("halt test done");
    endtask
    task automatic t_idle();
        d = 0; wr(ADDR_CTRL, 32'h00);
        for (i = 0; i < 99 && d[3] !== 1'h1; i++) rd(ADDR_CTRL);
        chk(d[3], 1);
        wr(ADDR_CTRL, 32'h40); wmode(ST_IDLE);
        chk({oscillator_enable_o, core_clock_enable_o, timer_clock_enable_o}, 4);
        wmode(ST_RUN); rd(ADDR_CTRL); chk(d[3], 1); chk(idle_timer_irq_o, 0);
        wr(ADDR_CTRL, 32'h02); wr(ADDR_CTRL, 32'h42);
        for (i = 0; i < 300 && service_first_o !== 1'h1; i++) @(posedge clk_i);
        chk(service_first_o, 1); @(posedge clk_i); chk(idle_timer_irq_o, 1);
        $display("idle test done");
    endtask
    // Reset for four cycles, then the scenarios.
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        t_regs();
        t_edge();
        t_halt();
        t_idle();
        end_sim();
    end
endmodule
`default_nettype wire
